// ### shared/dme_defs.vh
// Constants for the dual-mode serial EEPROM access block.
// Assumes a 10 MHz reference clock; all times are derived from it.
`ifndef DME_DEFS_VH
`define DME_DEFS_VH

// ==========================================================================
// Bus framing
// Chip-select field of the control byte
`define DME_CHIP_SEL    3'h0
// Bits per byte and the acknowledge slot index
`define DME_BYTE_BITS   4'h8

// ==========================================================================
// Array geometry
`define DME_MEM_WORDS   128
`define DME_PAGE_BYTES  8
`define DME_ADDR_ZERO   7'h00

// ==========================================================================
// Transmit-only mode
// Clocks held in high impedance after reset before the first bit
`define DME_INIT_CLKS   4'h9
// Idle transmit-only clock pulses that return the device to transmit-only
`define DME_SWAP_COUNT  8'h80

// ==========================================================================
// Timing
// Self-timed programming cycle in reference clocks: 10 ms at 10 MHz
`define DME_WR_CYCLES   20'h1_86A0

`endif

// ### rtl/dme_top.v
// Access logic of a 128x8 dual-mode serial EEPROM (slave side).
// Assumes all pins are asynchronous to I_REF_CLK and far slower than it;
// the board resolves the open-drain data wire from O_SDA_OE.
// Function
// - Page write past the page end wraps to the page start.
// - STOP ending a write command starts the timed programming cycle.
// - No acknowledge on any byte while programming is in progress.
// - Polling: write control byte is refused while busy, acknowledged after.
// - Bi-directional writes only happen while the transmit-only clock is high.
// - Address counter holds last accessed location plus one.
// - Read control byte is acknowledged, then eight bits sent MSB first.
// - Master no-acknowledge then STOP: device releases the data line.
// - Repeated START after word address loads pointer, abandons the write.
// - Master acknowledge during read makes the device send the next byte.
// - Pointer increments by one after each byte operation.
// - Low supply detector inhibits all erase and write activity.
// - Data change while SCL high is decoded as START or STOP.
// - Transmit-only mode sends array contents on the same data line.
// - SCL falling edge switches to bi-directional mode.
// - Transmit-only mode shifts one bit per transmit-only clock rise.
// - Respond only to own device code, chip select 000, plus direction.
// - Page write steps low three address bits, buffers up to eight bytes.
// - 128 idle transmit-only clocks return to transmit-only from 00h.
// - After reset nine clocks in high impedance, MSB on the tenth rise.
`timescale 1ns/1ps
`include "dme_defs.vh"

module dme_top #(
  parameter [3:0]  DEV_CODE  = 4'h6,            // Device-type code, value arbitrary
  parameter [19:0] WR_CYCLES = `DME_WR_CYCLES   // Programming cycle length in clocks
) (
  input  wire I_REF_CLK,
  input  wire I_RST,
  input  wire I_SCL,
  input  wire I_SDA,
  input  wire I_TRANSMIT_ONLY_CLOCK,
  input  wire I_SUPPLY_LOW,
  output reg  O_SDA_O,
  output reg  O_SDA_OE,
  output reg  O_MODE_TX_ONLY,
  output reg  O_BUSY
);

  // ========================================================================
  // State codes, one-hot
  localparam [5:0] ST_IDLE = 6'h01;
  localparam [5:0] ST_CTRL = 6'h02;
  localparam [5:0] ST_WORD = 6'h04;
  localparam [5:0] ST_WDAT = 6'h08;
  localparam [5:0] ST_RD   = 6'h10;
  localparam [5:0] ST_MACK = 6'h20;

  // ========================================================================
  // Pin synchronisers: stage 1 feeds stage 2 only, stage 3 is for edges
  reg  [3:0] sync1_r, sync2_r, sync3_r;

  always @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      sync1_r <= 4'hF;
      sync2_r <= 4'hF;
      sync3_r <= 4'hF;
    end else begin
      sync1_r <= {I_SUPPLY_LOW, I_TRANSMIT_ONLY_CLOCK, I_SDA, I_SCL};
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  wire scl_s    = sync2_r[0];
  wire sda_s    = sync2_r[1];
  wire tck_s    = sync2_r[2];
  wire vlow_s   = sync2_r[3];
  wire scl_rise = scl_s & ~sync3_r[0];
  wire scl_fall = ~scl_s & sync3_r[0];
  wire tck_rise = tck_s & ~sync3_r[2];
  // Data edges while the clock stays high are bus conditions
  wire start_c  = scl_s & sync3_r[0] & ~sda_s & sync3_r[1];
  wire stop_c   = scl_s & sync3_r[0] & sda_s & ~sync3_r[1];

  // ========================================================================
  // Storage and control registers
  reg  [7:0]  mem [0:`DME_MEM_WORDS-1];
  reg  [7:0]  pbuf [0:`DME_PAGE_BYTES-1];
  reg  [7:0]  mask_r;
  reg  [3:0]  wpage_r;
  reg  [5:0]  st_r;
  reg  [3:0]  cnt_r;
  reg         ackp_r;
  reg         rd_r;
  reg         mack_ok_r;
  reg  [7:0]  shin_r;
  reg  [7:0]  tx_r;
  reg  [6:0]  ptr_r;
  reg  [3:0]  init_r;
  reg  [2:0]  tobit_r;
  reg  [7:0]  swap_r;
  reg  [19:0] tmr_r;
  reg         flush_r;

  // ========================================================================
  // Two-entry read buffer between the array and the shifter
  reg  [7:0] ent0_r;
  reg  [7:0] ent1_r;
  reg  [1:0] fcnt_r;
  reg  [6:0] fptr_r;
  wire       push_rdy = (fcnt_r != 2'd2);
  wire       push_vld = ~O_BUSY & ~flush_r;
  wire       push     = push_vld & push_rdy;
  wire       pop_vld  = (fcnt_r != 2'd0);
  wire [7:0] head     = pop_vld ? ent0_r : 8'hFF;

  // Shifter asks for a byte: start of transmit-only byte or read byte
  wire to_go  = O_MODE_TX_ONLY & tck_rise & (init_r == `DME_INIT_CLKS) & (tobit_r == 3'd0);
  wire bd_go  = ~O_MODE_TX_ONLY & scl_fall & ~start_c & ~stop_c &
                (((st_r == ST_CTRL) & ackp_r & rd_r) | ((st_r == ST_MACK) & mack_ok_r));
  wire pop    = (to_go | bd_go) & pop_vld;
  wire commit = O_BUSY & (tmr_r == WR_CYCLES - 20'd1);
  wire ctl_ok = (shin_r[7:1] == {DEV_CODE, `DME_CHIP_SEL});

  // Buffer fill and drain; a stalled shifter simply leaves it full
  always @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      ent0_r <= 8'h00;
      ent1_r <= 8'h00;
      fcnt_r <= 2'd0;
      fptr_r <= 7'h00;
    end else if (flush_r) begin
      fcnt_r <= 2'd0;
      fptr_r <= ptr_r;
    end else begin
      if (push)
        fptr_r <= fptr_r + 7'h01;
      case ({push, pop})
        2'b10: begin
          if (fcnt_r == 2'd0)
            ent0_r <= mem[fptr_r];
          else
            ent1_r <= mem[fptr_r];
          fcnt_r <= fcnt_r + 2'd1;
        end
        2'b01: begin
          ent0_r <= ent1_r;
          fcnt_r <= fcnt_r - 2'd1;
        end
        2'b11: begin
          ent0_r <= (fcnt_r == 2'd1) ? mem[fptr_r] : ent1_r;
          ent1_r <= mem[fptr_r];
        end
        default: fcnt_r <= fcnt_r;
      endcase
    end
  end

  // ========================================================================
  // Array commit at the end of the programming cycle; page buffer loads
  integer i;
  always @(posedge I_REF_CLK) begin
    if (commit && !vlow_s) begin
      for (i = 0; i < `DME_PAGE_BYTES; i = i + 1) begin
        if (mask_r[i])
          mem[{wpage_r, i[2:0]}] <= pbuf[i];
      end
    end
    if (!O_MODE_TX_ONLY && scl_fall && !start_c && !stop_c && (st_r == ST_WDAT) &&
        (cnt_r == `DME_BYTE_BITS) && !ackp_r)
      pbuf[ptr_r[2:0]] <= shin_r;
  end

  // ========================================================================
  // Mode, protocol engine and programming timer
  always @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_SDA_O        <= 1'b0;
      O_SDA_OE       <= 1'b0;
      O_MODE_TX_ONLY <= 1'b1;
      O_BUSY         <= 1'b0;
      st_r           <= ST_IDLE;
      cnt_r          <= 4'h0;
      ackp_r         <= 1'b0;
      rd_r           <= 1'b0;
      mack_ok_r      <= 1'b0;
      shin_r         <= 8'h00;
      tx_r           <= 8'hFF;
      ptr_r          <= `DME_ADDR_ZERO;
      init_r         <= 4'h0;
      tobit_r        <= 3'd0;
      swap_r         <= 8'h00;
      tmr_r          <= 20'h0_0000;
      mask_r         <= 8'h00;
      wpage_r        <= 4'h0;
      flush_r        <= 1'b0;
    end else begin
      flush_r <= 1'b0;
      // Programming runs on its own once started; only the supply pin still matters, gating the array commit
      if (O_BUSY) begin
        tmr_r <= tmr_r + 20'h0_0001;
        if (commit) begin
          O_BUSY  <= 1'b0;
          mask_r  <= 8'h00;
          flush_r <= 1'b1;
        end
      end
      if (O_MODE_TX_ONLY) begin
        if (scl_fall) begin
          O_MODE_TX_ONLY <= 1'b0;
          O_SDA_OE       <= 1'b0;
          st_r           <= ST_IDLE;
          swap_r         <= 8'h00;
        end else if (tck_rise) begin
          if (init_r != `DME_INIT_CLKS) begin
            init_r <= init_r + 4'h1;
          end else if (tobit_r == 3'd0) begin
            tx_r     <= head;
            O_SDA_OE <= ~head[7];
            tobit_r  <= 3'd1;
          end else begin
            O_SDA_OE <= ~tx_r[3'd7 - tobit_r];
            tobit_r  <= tobit_r + 3'd1;
          end
        end
      end else begin
        // Idle pulse count on the transmit-only clock; any SCL fall clears it
        if (scl_fall)
          swap_r <= 8'h00;
        else if (tck_rise && scl_s && (st_r == ST_IDLE) && (swap_r != `DME_SWAP_COUNT))
          swap_r <= swap_r + 8'h01;
        if (swap_r == `DME_SWAP_COUNT) begin
          O_MODE_TX_ONLY <= 1'b1;
          ptr_r          <= `DME_ADDR_ZERO;
          flush_r        <= 1'b1;
          init_r         <= `DME_INIT_CLKS;
          tobit_r        <= 3'd0;
        end else if (start_c) begin
          // Repeated START drops a buffered page not yet programming; a running cycle keeps its page
          st_r     <= ST_CTRL;
          cnt_r    <= 4'h0;
          ackp_r   <= 1'b0;
          O_SDA_OE <= 1'b0;
          flush_r  <= 1'b1;
          if (!O_BUSY)
            mask_r <= 8'h00;
        end else if (stop_c) begin
          st_r     <= ST_IDLE;
          O_SDA_OE <= 1'b0;
          flush_r  <= 1'b1;
          // Write-protect and supply level are judged at the STOP
          if ((st_r == ST_WDAT) && (mask_r != 8'h00) && !O_BUSY) begin
            if (tck_s && !vlow_s) begin
              O_BUSY <= 1'b1;
              tmr_r  <= 20'h0_0000;
            end else begin
              mask_r <= 8'h00;
            end
          end
        end else if (scl_rise) begin
          if ((st_r & (ST_CTRL | ST_WORD | ST_WDAT)) != 6'h00) begin
            if (cnt_r != `DME_BYTE_BITS) begin
              shin_r <= {shin_r[6:0], sda_s};
              cnt_r  <= cnt_r + 4'h1;
            end
          end else if (st_r == ST_RD) begin
            cnt_r <= cnt_r + 4'h1;
          end else if (st_r == ST_MACK) begin
            mack_ok_r <= ~sda_s;
          end
        end else if (scl_fall) begin
          case (st_r)
            ST_CTRL, ST_WORD, ST_WDAT: begin
              if ((cnt_r == `DME_BYTE_BITS) && !ackp_r) begin
                ackp_r <= 1'b1;
                if (st_r == ST_CTRL) begin
                  if (ctl_ok && !O_BUSY) begin
                    O_SDA_OE <= 1'b1;
                    rd_r     <= shin_r[0];
                  end else begin
                    st_r <= ST_IDLE;
                  end
                end else if (st_r == ST_WORD) begin
                  O_SDA_OE <= 1'b1;
                  ptr_r    <= shin_r[6:0];
                  wpage_r  <= shin_r[6:3];
                  flush_r  <= 1'b1;
                end else begin
                  O_SDA_OE             <= 1'b1;
                  mask_r[ptr_r[2:0]]   <= 1'b1;
                  ptr_r[2:0]           <= ptr_r[2:0] + 3'd1;
                end
              end else if (ackp_r) begin
                ackp_r <= 1'b0;
                cnt_r  <= 4'h0;
                if ((st_r == ST_CTRL) && rd_r) begin
                  st_r     <= ST_RD;
                  tx_r     <= head;
                  O_SDA_OE <= ~head[7];
                end else begin
                  O_SDA_OE <= 1'b0;
                  if (st_r == ST_CTRL)
                    st_r <= ST_WORD;
                  else
                    st_r <= ST_WDAT;
                end
              end
            end
            ST_RD: begin
              if (cnt_r == `DME_BYTE_BITS) begin
                O_SDA_OE  <= 1'b0;                         // Leave the ack slot to the master
                st_r      <= ST_MACK;
                mack_ok_r <= 1'b0;
              end else if (cnt_r != 4'h0) begin
                O_SDA_OE <= ~tx_r[6];
                tx_r     <= {tx_r[6:0], 1'b1};
              end
            end
            ST_MACK: begin
              cnt_r <= 4'h0;
              if (mack_ok_r) begin
                st_r     <= ST_RD;
                tx_r     <= head;
                O_SDA_OE <= ~head[7];
              end else begin
                st_r     <= ST_IDLE;
                O_SDA_OE <= 1'b0;
              end
            end
            default: O_SDA_OE <= 1'b0;
          endcase
        end
      end
      // Every byte handed to the shifter advances the pointer
      if (pop)
        ptr_r <= ptr_r + 7'h01;
    end
  end

endmodule

// ### sim/dme_master.sv
// Two-wire bus master model that drives the bus clock and its side of the data wire.
// Assumes the bench resolves the open-drain data wire and feeds it back on sda_in.
`timescale 1ns/1ps
module dme_master (
  input  wire clk,
  input  wire sda_in,
  output reg  scl,
  output reg  sda
);
  // ==========================================================================
  // Bus primitives, paced on the falling edge of the reference clock
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end
  task tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  // Data is raised while the clock is low, so this also serves as a repeated start
  task start;
    sda = 1'b1;
    tick(3);
    scl = 1'b1;
    tick(5);
    sda = 1'b0;
    tick(5);
    scl = 1'b0;
    tick(2);
  endtask
  task stop;
    sda = 1'b0;
    tick(3);
    scl = 1'b1;
    tick(5);
    sda = 1'b1;
    tick(5);
  endtask
  // Data moves two clocks after the bus clock falls, never while it is high
  task bitx(input logic b, output logic r);
    tick(2);
    sda = b;
    tick(4);
    scl = 1'b1;
    tick(5);
    r = sda_in;
    tick(5);
    scl = 1'b0;
  endtask
  task wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(d[i], r);
    bitx(1'b1, r);
    ack = ~r;
  endtask
  // Master acknowledge asks for the next byte; no acknowledge ends the read
  task rbyte(input logic mack, output logic [7:0] d);
    logic r;
    for (int i = 0; i < 8; i++) begin
      bitx(1'b1, r);
      d = {d[6:0], r};
    end
    bitx(~mack, r);
  endtask
  // A single falling edge with data released, used to leave transmit-only mode
  task wiggle;
    scl = 1'b0;
    tick(5);
    scl = 1'b1;
    tick(5);
  endtask
endmodule

// ### sim/dme_top_checker.sv
// Concurrent checks on the ports of the serial EEPROM access block.
// Assumes pins change on the falling clock edge and a two-flop synchroniser.
`timescale 1ns/1ps
module dme_top_checker #(
  parameter [19:0] WR_CYCLES = 20'h0_0014
) (
  input wire I_REF_CLK,
  input wire I_RST,
  input wire I_SCL,
  input wire I_SDA,
  input wire I_TRANSMIT_ONLY_CLOCK,
  input wire I_SUPPLY_LOW,
  input wire O_SDA_O,
  input wire O_SDA_OE,
  input wire O_MODE_TX_ONLY,
  input wire O_BUSY
);
  reg [19:0] busy_cnt_r;
  reg [3:0]  stop_age_r;
  reg [3:0]  init_rises_r;
  reg [7:0]  idle_rises_r;
  reg        init_phase_r;
  reg        toc_q_r;
  reg        sda_q_r;
  wire       toc_rise = I_TRANSMIT_ONLY_CLOCK & ~toc_q_r;
  // ==========================================================================
  // Helper counters on raw pins; bounds below allow for the synchroniser delay
  always @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      busy_cnt_r   <= 20'h0_0000;
      stop_age_r   <= 4'hF;
      init_rises_r <= 4'h0;
      idle_rises_r <= 8'h00;
      init_phase_r <= 1'b1;
      toc_q_r      <= 1'b1;
      sda_q_r      <= 1'b1;
    end else begin
      toc_q_r      <= I_TRANSMIT_ONLY_CLOCK;
      sda_q_r      <= I_SDA;
      busy_cnt_r   <= O_BUSY ? busy_cnt_r + 20'h0_0001 : 20'h0_0000;
      stop_age_r   <= (I_SCL & I_SDA & ~sda_q_r) ? 4'h0 :
                      (stop_age_r == 4'hF) ? 4'hF : stop_age_r + 4'h1;
      init_rises_r <= (toc_rise && init_rises_r != 4'hF) ? init_rises_r + 4'h1 : init_rises_r;
      init_phase_r <= init_phase_r & O_MODE_TX_ONLY;
      idle_rises_r <= (O_MODE_TX_ONLY | ~I_SCL) ? 8'h00 : idle_rises_r + {7'h00, toc_rise};
    end
  end
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (I_RST);
  sequence s_scl_fall;
    $fell(I_SCL);
  endsequence
  sequence s_to_bidir;
    ##[1:6] !O_MODE_TX_ONLY;
  endsequence
  a_ack_scl_low: assert property ($rose(O_SDA_OE) && !O_MODE_TX_ONLY |-> !I_SCL && !$past(I_SCL, 2))
    else $error("Data line pulled low while the bus clock was high");
  a_busy_length: assert property ($fell(O_BUSY) |-> busy_cnt_r == WR_CYCLES)
    else $error("Programming cycle length differs from the set count");
  a_busy_after_stop: assert property ($rose(O_BUSY) |-> stop_age_r <= 4'h8)
    else $error("Programming began without a recent stop condition");
  a_busy_no_ack: assert property (O_BUSY |-> !O_SDA_OE)
    else $error("Data line driven during the programming cycle");
  a_write_gated: assert property ($rose(O_BUSY) |->
    $past(I_TRANSMIT_ONLY_CLOCK, 3) && !$past(I_SUPPLY_LOW, 3))
    else $error("Programming began with writes inhibited");
  a_mode_bidir: assert property (O_MODE_TX_ONLY ##0 s_scl_fall |-> s_to_bidir)
    else $error("Bus clock fall did not select bi-directional mode");
  a_mode_hold: assert property ($fell(O_MODE_TX_ONLY) |-> !$past(I_SCL, 2))
    else $error("Left transmit-only mode with the bus clock high");
  a_init_quiet: assert property (init_phase_r && O_MODE_TX_ONLY && init_rises_r <= 4'h9
    |-> !O_SDA_OE)
    else $error("Data line driven within the first nine clocks");
  a_return_tx: assert property ($rose(O_MODE_TX_ONLY) |-> idle_rises_r == 8'h80)
    else $error("Returned to transmit-only mode at the wrong count");
  a_drive_low: assert property (O_SDA_OE |-> !O_SDA_O)
    else $error("Data line driven to a high level");
endmodule
bind dme_top dme_top_checker #(.WR_CYCLES(WR_CYCLES)) u_chk (
  .I_REF_CLK(I_REF_CLK), .I_RST(I_RST), .I_SCL(I_SCL), .I_SDA(I_SDA),
  .I_TRANSMIT_ONLY_CLOCK(I_TRANSMIT_ONLY_CLOCK), .I_SUPPLY_LOW(I_SUPPLY_LOW),
  .O_SDA_O(O_SDA_O), .O_SDA_OE(O_SDA_OE), .O_MODE_TX_ONLY(O_MODE_TX_ONLY), .O_BUSY(O_BUSY));

// ### sim/testbench.sv
// Self-checking bench for the serial EEPROM access block with a bus master model.
// Assumes an open-drain data wire with a pull-up and a 10 MHz reference clock.
`timescale 1ns/1ps
module testbench;
  localparam [3:0] DC = 4'h6; // Device code, value arbitrary
  localparam [7:0] CW = {DC, 3'b000, 1'b0};
  localparam [7:0] CR = {DC, 3'b000, 1'b1};
  reg        clk = 1'b0;
  reg        rst = 1'b1;
  reg        toc = 1'b1;
  reg        sup = 1'b0;
  wire       scl, sda_m, oe, mode, busy, sdo;
  // Open drain: an enabled driver pulls the wire low when it drives 0, never forces it high
  wire       sda = sda_m & (~oe | sdo);
  logic [7:0] mem [128];
  int        n_fail = 0;
  int        n_checks = 0;
  // ==========================================================================
  // Clock, master model and the block under test
  always #50 clk = ~clk;
  dme_master m (.clk(clk), .sda_in(sda), .scl(scl), .sda(sda_m));
  dme_top #(.DEV_CODE(DC), .WR_CYCLES(20'h0_0258)) uut (
    .I_REF_CLK(clk), .I_RST(rst), .I_SCL(scl), .I_SDA(sda), .I_TRANSMIT_ONLY_CLOCK(toc),
    .I_SUPPLY_LOW(sup), .O_SDA_O(sdo), .O_SDA_OE(oe), .O_MODE_TX_ONLY(mode), .O_BUSY(busy));
  task chk(input logic [7:0] e, input logic [7:0] g, input string nm);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task results;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Transmit-only clock at 800 ns, eight reference clocks per pulse
  task tocp(input int n);
    repeat (n) begin
      toc = 1'b0;
      m.tick(4);
      toc = 1'b1;
      m.tick(4);
    end
  endtask
  // Expected array is updated only when the write is allowed to program
  task wr(input [6:0] a, input int n, input [7:0] b);
    logic k, acc;
    acc = 1'b1;
    m.start;
    m.wbyte(CW, k);
    acc &= k;
    m.wbyte({1'b0, a}, k);
    acc &= k;
    for (int i = 0; i < n; i++) begin
      m.wbyte(b + i, k);
      acc &= k;
      if (toc && !sup) mem[{a[6:3], 3'(a[2:0] + i)}] = b + i;
    end
    m.stop;
    chk(1, acc, "write acks");
  endtask
  // Polling starts straight after the stop; the first try must be refused
  task poll;
    logic k;
    int t;
    t = 0;
    m.start;
    m.wbyte(CW, k);
    m.stop;
    chk(0, k, "poll while busy");
    while (!k && t < 10) begin
      m.start;
      m.wbyte(CW, k);
      m.stop;
      t++;
    end
    chk(1, k, "poll after cycle");
  endtask
  task rd(input [6:0] a, input int n);
    logic k;
    logic [7:0] d;
    m.start;
    m.wbyte(CW, k);
    m.wbyte({1'b0, a}, k);
    m.start;
    m.wbyte(CR, k);
    chk(1, k, "read control ack");
    for (int i = 0; i < n; i++) begin
      m.rbyte(i < n - 1, d);
      chk(mem[7'(a + i)], d, "read data");
    end
    m.stop;
    chk(0, oe, "line released");
  endtask
  task t_init;
    for (int i = 0; i < 9; i++) begin
      tocp(1);
      chk(0, oe, "quiet start clocks");
    end
    m.wiggle;
    chk(0, mode, "bi-directional mode");
    $display("t_init done");
  endtask
  // Nine bytes into one page: the last wraps onto the first slot
  task t_page;
    wr(7'h00, 9, 8'h10);
    chk(1, busy, "cycle started");
    poll;
    rd(7'h00, 8);
    $display("t_page done");
  endtask
  task t_wrap;
    logic k;
    logic [7:0] d;
    wr(7'h7F, 1, 8'hC3);
    poll;
    rd(7'h7F, 2);
    m.start;
    m.wbyte(CR, k);
    m.rbyte(1'b0, d);
    m.stop;
    chk(mem[1], d, "current address read");
    $display("t_wrap done");
  endtask
  task t_block;
    for (int c = 0; c < 2; c++) begin
      toc = (c != 0);
      sup = (c != 0);
      wr(7'h7F, 1, 8'h5A);
      m.tick(5);
      chk(0, busy, "write inhibited");
      toc = 1'b1;
      sup = 1'b0;
      rd(7'h7F, 1);
    end
    $display("t_block done");
  endtask
  task t_code;
    logic k;
    logic [7:0] bad [2];
    bad = '{{~DC, 3'b000, 1'b0}, {DC, 3'b100, 1'b0}};
    for (int c = 0; c < 2; c++) begin
      m.start;
      m.wbyte(bad[c], k);
      m.stop;
      chk(0, k, "foreign control byte");
    end
    $display("t_code done");
  endtask
  // Idle bus clock while transmit-only pulses run brings back the stream from 00h
  task t_ret;
    logic [7:0] d;
    tocp(127);
    chk(0, mode, "count below limit");
    tocp(1);
    chk(1, mode, "transmit-only again");
    for (int i = 0; i < 8; i++) begin
      tocp(1);
      d = {d[6:0], sda};
    end
    chk(mem[0], d, "streamed byte");
    $display("t_ret done");
  endtask
  // Main sequence and watchdog share the closing task
  initial begin
    m.tick(20);
    rst = 1'b0;
    m.tick(3);
    t_init;
    t_page;
    t_wrap;
    t_block;
    t_code;
    t_ret;
    results;
  end
  initial begin
    repeat (40000) @(negedge clk);
    n_fail++;
    $display("watchdog expired");
    results;
  end
endmodule
